// >>> core/flash_link_pkg.sv
// shared constants, types and timing counts of the serial flash link
package flash_link_pkg;

  // core clock rate
  localparam int CLK_MHZ = 100;
  localparam int NS_PER_US = 1000;
  localparam int CNT_W = 22;

  // documented times, in their printed units
  localparam int T_WP_US = 1;
  localparam int T_LOCK_US = 200;
  localparam int T_EUDPD_US = 3;
  localparam int T_CSLU_NS = 20;
  localparam int T_XUDPD_US = 100;
  localparam int T_EDPD_US = 2;
  localparam int T_RDPD_US = 35;
  localparam int T_XFR_US = 180;
  localparam int T_EP_TYP_MS = 10;
  localparam int T_OTP_TYP_US = 200;
  localparam int US_PER_MS = 1000;

  // longest times round down, least times round up
  localparam int WP_CYC = T_WP_US * CLK_MHZ;
  localparam int LOCK_CYC = T_LOCK_US * CLK_MHZ;
  localparam int EUDPD_CYC = T_EUDPD_US * CLK_MHZ;
  localparam int CSLU_CYC = (T_CSLU_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int XUDPD_CYC = T_XUDPD_US * CLK_MHZ;
  localparam int EDPD_CYC = T_EDPD_US * CLK_MHZ;
  localparam int RDPD_CYC = T_RDPD_US * CLK_MHZ;
  localparam int XFR_CYC = T_XFR_US * CLK_MHZ;
  localparam int EP_CYC = T_EP_TYP_MS * US_PER_MS * CLK_MHZ;
  localparam int OTP_CYC = T_OTP_TYP_US * CLK_MHZ;

  // command opcodes understood by the sequencer
  localparam logic [7:0] OP_XFER = 8'h53;
  localparam logic [7:0] OP_COMP = 8'h60;
  localparam logic [7:0] OP_ERASE_PROG = 8'h83;
  localparam logic [7:0] OP_OTP_PROG = 8'h9b;
  localparam logic [7:0] OP_FREEZE = 8'h7f;
  localparam logic [7:0] OP_DPD = 8'hb9;
  localparam logic [7:0] OP_RESUME = 8'hab;
  localparam logic [7:0] OP_UDPD = 8'h79;

  // status byte shifted out on every frame
  typedef struct packed {
    logic [2:0] spare;
    logic       ultraDeep;
    logic       deepPowerDown;
    logic       lockFrozen;
    logic       protect;
    logic       busy;
  } status_t;

  // one received byte and whether it opened the frame
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } rx_word_t;

  typedef enum logic [6:0] {
    S_IDLE       = 7'h01,
    S_BUSY       = 7'h02,
    S_ENTER_DPD  = 7'h04,
    S_DPD        = 7'h08,
    S_ENTER_UDPD = 7'h10,
    S_UDPD       = 7'h20,
    S_WAKE       = 7'h40
  } state_t;

endpackage : flash_link_pkg

// >>> core/serial_shifter.sv
// link-clock side: byte shifter on sck, cleared while chip select is high
module serial_shifter (
  input  wire logic                    sck,
  input  wire logic                    csN,
  input  wire logic                    rstn,
  input  wire logic                    mosi,
  input  wire flash_link_pkg::status_t txByte,
  output flash_link_pkg::rx_word_t     rxWord,
  output logic                         rxToggle,
  output logic                         miso,
  output logic                         misoOe
);

  typedef struct packed {
    logic [2:0] bitCnt;
    logic [6:0] shiftIn;
    logic       notFirst;
  } frame_t;

  frame_t frame;
  frame_t next_frame;

  // frame counters; sck may stop between frames, so csN clears them
  always_comb
  begin
    next_frame = frame;
    next_frame.shiftIn = {frame.shiftIn[5:0], mosi};
    next_frame.bitCnt = frame.bitCnt + 3'h1;
    if (frame.bitCnt == 3'h7)
      next_frame.notFirst = 1'b1;
  end

  // input sampled on the rising edge
  always_ff @(posedge sck or posedge csN)
  begin
    if (csN)
      frame <= '0;
    else
      frame <= next_frame;
  end

  // completed byte held stable for 8 sck periods, toggle marks it
  always_ff @(posedge sck or negedge rstn)
  begin
    if (!rstn)
    begin
      rxWord <= '0;
      rxToggle <= 1'b0;
    end
    else if (!csN && frame.bitCnt == 3'h7)
    begin
      rxWord <= '{first: !frame.notFirst, data: {frame.shiftIn, mosi}};
      rxToggle <= !rxToggle;
    end
  end

  // output launched on the falling edge
  // status is quasi-static, so no word crossing is spent on it
  always_ff @(negedge sck or posedge csN)
  begin
    if (csN)
    begin
      miso <= 1'b0;
      misoOe <= 1'b0;
    end
    else
    begin
      miso <= txByte[3'h7 - frame.bitCnt];
      misoOe <= 1'b1;
    end
  end

endmodule : serial_shifter

// >>> core/serial_flash_link.sv
// core side of the serial flash link: command sequencer and timers
// Operation
// - The memory shifts bits out on falling sck and samples on rising.
// - Protection follows the protect pin within 1 us either way.
// - Lockdown freezing completes within 200 us after chip select rises.
// - Ultra-deep power-down is entered within 3 us after chip select.
// - Chip select low for 20 ns wakes it; ready again within 100 us.
// - Deep power-down starts within 2 us; resume is ready in 35 us.
// - Page to buffer transfer and compare finish within 180 us.
// - Page erase and program finishes within 35 ms, typically 10 ms.
// - Security register programming finishes within 500 us.
module serial_flash_link #(
  parameter int LOCK_CYC  = flash_link_pkg::LOCK_CYC,
  parameter int XUDPD_CYC = flash_link_pkg::XUDPD_CYC,
  parameter int XFR_CYC   = flash_link_pkg::XFR_CYC,
  parameter int EP_CYC    = flash_link_pkg::EP_CYC,
  parameter int OTP_CYC   = flash_link_pkg::OTP_CYC
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic mosi,
  input  wire logic wpN,
  output logic      miso,
  output logic      misoOe,
  output logic      busy,
  output logic      protect,
  output logic      lockFrozen,
  output logic      deepPowerDown,
  output logic      ultraDeep
);

  localparam int W = flash_link_pkg::CNT_W;

  typedef struct packed {
    flash_link_pkg::state_t  state;
    logic [W-1:0]            cnt;
    logic [7:0]              opcode;
    logic                    haveOp;
    logic                    freezing;
    flash_link_pkg::status_t status;
    logic                    csS1;
    logic                    csS2;
    logic                    csPrev;
    logic                    wpS1;
    logic                    wpS2;
    logic                    tgS1;
    logic                    tgS2;
    logic                    tgS3;
  } core_t;

  core_t q;
  core_t next_q;

  flash_link_pkg::rx_word_t rxWord;
  logic                     rxToggle;
  logic                     csRise;
  logic                     rxEvent;
  logic                     cmdSeen;
  logic [7:0]               cmdCode;

  // cycle count of a timer, sized to the counter
  function automatic logic [W-1:0] cycles(input int n);
    cycles = n[W-1:0];
  endfunction : cycles

  // last cycle of a loaded countdown
  function automatic logic lastTick(input logic [W-1:0] c);
    lastTick = (c <= W'(1));
  endfunction : lastTick

  serial_shifter link (
    .sck      (sck),
    .csN      (csN),
    .rstn     (rstn),
    .mosi     (mosi),
    .txByte   (q.status),
    .rxWord   (rxWord),
    .rxToggle (rxToggle),
    .miso     (miso),
    .misoOe   (misoOe)
  );

  // edges seen only past the second synchroniser flop
  assign csRise = q.csS2 && !q.csPrev;
  assign rxEvent = q.tgS2 ^ q.tgS3;

  // a command byte landing in the csN-rise cycle still counts, so a
  // short last half-cycle never loses the opcode or leaves it pending
  assign cmdSeen = q.haveOp || (rxEvent && rxWord.first);
  assign cmdCode = (rxEvent && rxWord.first) ? rxWord.data : q.opcode;

  // sequencer
  always_comb
  begin
    next_q = q;
    // two-flop synchronisers; a 30 ns high gap spans these edges
    next_q.csS1 = csN;
    next_q.csS2 = q.csS1;
    next_q.csPrev = q.csS2;
    next_q.wpS1 = wpN;
    next_q.wpS2 = q.wpS1;
    next_q.tgS1 = rxToggle;
    next_q.tgS2 = q.tgS1;
    next_q.tgS3 = q.tgS2;
    // protect pin reaches the status in 3 cycles, well under 1 us
    next_q.status.protect = !q.wpS2;
    // opening byte of a frame is the command
    if (rxEvent && rxWord.first)
    begin
      next_q.opcode = rxWord.data;
      next_q.haveOp = 1'b1;
    end
    if (csRise)
      next_q.haveOp = 1'b0;
    if (q.cnt != '0)
      next_q.cnt = q.cnt - W'(1);
    case (q.state)
      flash_link_pkg::S_IDLE:
      begin
        if (csRise && cmdSeen)
        begin
          case (cmdCode)
            flash_link_pkg::OP_XFER,
            flash_link_pkg::OP_COMP:
            begin
              next_q.cnt = cycles(XFR_CYC);
              next_q.state = flash_link_pkg::S_BUSY;
            end
            flash_link_pkg::OP_ERASE_PROG:
            begin
              // protected array refuses programming
              if (!q.status.protect)
              begin
                next_q.cnt = cycles(EP_CYC);
                next_q.state = flash_link_pkg::S_BUSY;
              end
            end
            flash_link_pkg::OP_OTP_PROG:
            begin
              if (!q.status.protect)
              begin
                next_q.cnt = cycles(OTP_CYC);
                next_q.state = flash_link_pkg::S_BUSY;
              end
            end
            flash_link_pkg::OP_FREEZE:
            begin
              next_q.cnt = cycles(LOCK_CYC);
              next_q.freezing = 1'b1;
              next_q.state = flash_link_pkg::S_BUSY;
            end
            flash_link_pkg::OP_DPD:
            begin
              next_q.cnt = cycles(flash_link_pkg::EDPD_CYC);
              next_q.state = flash_link_pkg::S_ENTER_DPD;
            end
            flash_link_pkg::OP_UDPD:
            begin
              next_q.cnt = cycles(flash_link_pkg::EUDPD_CYC);
              next_q.state = flash_link_pkg::S_ENTER_UDPD;
            end
            default:
            begin
              next_q.state = flash_link_pkg::S_IDLE;
            end
          endcase
          next_q.status.busy = (next_q.state != flash_link_pkg::S_IDLE);
        end
      end
      flash_link_pkg::S_BUSY:
      begin
        // commands are ignored while busy shows
        if (lastTick(q.cnt))
        begin
          next_q.state = flash_link_pkg::S_IDLE;
          next_q.status.busy = 1'b0;
          if (q.freezing)
            next_q.status.lockFrozen = 1'b1;
          next_q.freezing = 1'b0;
        end
      end
      flash_link_pkg::S_ENTER_DPD:
      begin
        if (lastTick(q.cnt))
        begin
          next_q.state = flash_link_pkg::S_DPD;
          next_q.status.deepPowerDown = 1'b1;
          next_q.status.busy = 1'b0;
        end
      end
      flash_link_pkg::S_DPD:
      begin
        // only resume is heard in deep power-down
        if (csRise && cmdSeen && cmdCode == flash_link_pkg::OP_RESUME)
        begin
          next_q.cnt = cycles(flash_link_pkg::RDPD_CYC);
          next_q.status.busy = 1'b1;
          next_q.state = flash_link_pkg::S_WAKE;
        end
      end
      flash_link_pkg::S_ENTER_UDPD:
      begin
        if (lastTick(q.cnt))
        begin
          next_q.state = flash_link_pkg::S_UDPD;
          next_q.status.ultraDeep = 1'b1;
          next_q.status.busy = 1'b0;
        end
      end
      flash_link_pkg::S_UDPD:
      begin
        // count low chip select; a short glitch does not wake
        if (q.csS2)
          next_q.cnt = '0;
        else if (q.cnt >= cycles(flash_link_pkg::CSLU_CYC) - W'(1))
        begin
          next_q.cnt = cycles(XUDPD_CYC);
          next_q.status.busy = 1'b1;
          next_q.state = flash_link_pkg::S_WAKE;
        end
        else
          next_q.cnt = q.cnt + W'(1);
      end
      flash_link_pkg::S_WAKE:
      begin
        // power-down flags drop when ready again
        if (lastTick(q.cnt))
        begin
          next_q.state = flash_link_pkg::S_IDLE;
          next_q.status.busy = 1'b0;
          next_q.status.deepPowerDown = 1'b0;
          next_q.status.ultraDeep = 1'b0;
        end
      end
      default:
      begin
        next_q.state = flash_link_pkg::S_IDLE;
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.state <= flash_link_pkg::S_IDLE;
      // idle pin levels: no false csN edge, no protect blip after reset
      q.csS1 <= 1'b1;
      q.csS2 <= 1'b1;
      q.csPrev <= 1'b1;
      q.wpS1 <= 1'b1;
      q.wpS2 <= 1'b1;
    end
    else
      q <= next_q;
  end

  // status outputs straight from flops
  assign busy = q.status.busy;
  assign protect = q.status.protect;
  assign lockFrozen = q.status.lockFrozen;
  assign deepPowerDown = q.status.deepPowerDown;
  assign ultraDeep = q.status.ultraDeep;

endmodule : serial_flash_link

// >>> test/flash_link_props.sv
// assertions on the core-side ports of the serial flash link
module flash_link_props #(
  parameter int LOCK_CYC  = 50,
  parameter int XUDPD_CYC = 40
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic wpN,
  input wire logic misoOe,
  input wire logic busy,
  input wire logic protect,
  input wire logic lockFrozen,
  input wire logic deepPowerDown,
  input wire logic ultraDeep
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  int run;
  // length of a busy stretch, valid at the edge where it ends
  always_ff @(posedge core_clk)
  begin
    run <= (rstn && busy) ? run + 1 : 0;
  end
  sequence ends_after(int n);
    $fell(busy) && run == n;
  endsequence
  sequence wake_req;
    (ultraDeep && !busy && !csN)[*2];
  endsequence
  wp_follow_a: assert property (
    protect == $past(!wpN, 3)) else $error("protect lag wrong");
  lock_time_a: assert property (
    $rose(lockFrozen) |-> ends_after(LOCK_CYC)) else $error("freeze time");
  lock_stay_a: assert property (
    lockFrozen |=> lockFrozen) else $error("lock lost");
  udpd_in_a: assert property (
    $rose(ultraDeep) |-> ends_after(300)) else $error("udpd entry");
  wake_go_a: assert property (
    wake_req |-> ##[0:5] busy) else $error("no wake");
  udpd_out_a: assert property (
    $fell(ultraDeep) |-> ends_after(XUDPD_CYC)) else $error("udpd exit");
  ud_quiet_a: assert property (
    ultraDeep && csN && !busy |=> ultraDeep) else $error("ud left");
  dpd_in_a: assert property (
    $rose(deepPowerDown) |-> ends_after(200)) else $error("dpd entry");
  dpd_out_a: assert property (
    $fell(deepPowerDown) |-> ends_after(3500)) else $error("dpd exit");
  miso_idle_a: assert property (
    csN |-> !misoOe) else $error("miso driven idle");
endmodule : flash_link_props

// >>> test/flash_host_model.sv
// host controller model: mode 0 frames on the serial link
module flash_host_model (
  output logic      sck,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock rests low and select high between frames
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // two-byte frame; rx holds bits caught at falling edges
  // only general commands here, so no slower read ceiling applies
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    #36;
    csN = 1'b0;
    mosi = tx[15];
    #6;
    for (int i = 14; i >= -1; i--)
    begin
      sck = 1'b1; // 83 MHz: within 85 MHz and 104 MHz
      #1; // clear of the sampling edge
      mosi = (i >= 0) ? tx[i & 15] : ~mosi;
      #5;
      rx = {rx[14:0], miso};
      sck = 1'b0;
      #6;
    end
    csN = 1'b1;
  endtask : frame
  // bare select pulse, no clock, to leave ultra-deep sleep
  task automatic wake();
    #36;
    csN = 1'b0;
    #30;
    csN = 1'b1;
  endtask : wake
endmodule : flash_host_model

// >>> test/serial_flash_link_tb.sv
// self-checking bench for the serial flash link core
module serial_flash_link_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOCK = 50;
  localparam int XUDPD = 40;
  localparam int XFR = 30;
  localparam int EP = 60;
  localparam int OTP = 40;
  logic        core_clk;
  logic        rstn;
  logic        wpN;
  logic [2:0]  flags;
  logic [15:0] rx;
  wire         sck, csN, mosi, miso, misoOe, busy, protect;
  wire         lockFrozen, deepPowerDown, ultraDeep;
  int          fail_count = 0;
  int          compares = 0;
  serial_flash_link #(.LOCK_CYC(LOCK), .XUDPD_CYC(XUDPD), .XFR_CYC(XFR),
    .EP_CYC(EP), .OTP_CYC(OTP)) dut_u (.core_clk, .rstn, .sck, .csN,
    .mosi, .wpN, .miso, .misoOe, .busy, .protect, .lockFrozen,
    .deepPowerDown, .ultraDeep);
  flash_host_model host_u (.sck, .csN, .mosi, .miso);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // count busy cycles; a refused command never raises busy
  task automatic measure(int dur);
    int n = 0;
    int k = 0;
    while (busy !== 1'b1 && k < 12)
    begin
      @(posedge core_clk);
      k++;
    end
    while (busy === 1'b1 && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 5000)
    begin
      fail_count++;
      end_of_test();
    end
    else
      check("busy cycles", n, dur);
  endtask : measure
  // one command frame; status read back from its second byte
  task automatic op(logic [7:0] code, int dur, logic [2:0] after);
    host_u.frame({code, 8'h00}, rx);
    check("status", rx[7:0], {3'h0, flags, ~wpN, 1'b0});
    measure(dur);
    flags = after;
    check("flags", {ultraDeep, deepPowerDown, lockFrozen},
      flags);
  endtask : op
  initial
  begin
    rstn = 1'b0;
    wpN = 1'b1;
    flags = 3'b000;
    void'($urandom(32'h4dfb));
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("reset", {busy, protect, lockFrozen, deepPowerDown},
      4'h0);
    // random protect pin levels
    repeat (6)
    begin
      wpN <= 1'($urandom);
      repeat (4) @(posedge core_clk);
      check("protect", protect, !wpN);
    end
    wpN <= 1'b1;
    repeat (4) @(posedge core_clk);
    op(flash_link_pkg::OP_XFER, XFR, 3'b000);
    op(flash_link_pkg::OP_COMP, XFR, 3'b000);
    op(flash_link_pkg::OP_ERASE_PROG, EP, 3'b000);
    op(flash_link_pkg::OP_OTP_PROG, OTP, 3'b000);
    op(flash_link_pkg::OP_FREEZE, LOCK, 3'b001);
    wpN <= 1'b0;
    repeat (4) @(posedge core_clk);
    op(flash_link_pkg::OP_ERASE_PROG, 0, 3'b001);
    op(flash_link_pkg::OP_OTP_PROG, 0, 3'b001);
    wpN <= 1'b1;
    repeat (4) @(posedge core_clk);
    op({4'h1, 4'($urandom)}, 0, 3'b001); // unknown code ignored
    op(flash_link_pkg::OP_DPD, 200, 3'b011);
    op(flash_link_pkg::OP_XFER, 0, 3'b011);
    op(flash_link_pkg::OP_RESUME, 3500, 3'b001);
    op(flash_link_pkg::OP_UDPD, 300, 3'b101);
    fork
      host_u.wake();
      measure(XUDPD);
    join
    check("woken", {ultraDeep, deepPowerDown, lockFrozen},
      3'b001);
    end_of_test();
  end
  // hang guard
  initial
  begin
    #100us;
    fail_count++;
    end_of_test();
  end
endmodule : serial_flash_link_tb

bind serial_flash_link flash_link_props #(
  .LOCK_CYC(LOCK_CYC),
  .XUDPD_CYC(XUDPD_CYC)
) props_u (.core_clk, .rstn, .csN, .wpN, .misoOe, .busy, .protect,
  .lockFrozen, .deepPowerDown, .ultraDeep);
